//--- bfp_addr_decode.sv
// combinational pointer split and section decode
`timescale 1ns/1ns
`default_nettype none
module bfp_addr_decode (
    input wire logic part_8k,
    input wire logic [1:0] boot_size,
    input wire logic [bfp_pkg::PTR_W-1:0] ptr,
    output bfp_pkg::bfp_map_s map
);
    logic [bfp_pkg::PC_W-1:0] vec;
    logic [bfp_pkg::PC_W-1:0] pc;

    always_comb begin
        vec = bfp_pkg::boot_start(part_8k, boot_size);
        if (part_8k) begin
            // top two pointer bits fall outside the slice
            pc = ptr[bfp_pkg::PTR_PC_TOP_8K:bfp_pkg::PTR_WORD_LSB];
            map.page_index = ptr[bfp_pkg::PTR_PC_TOP_8K:bfp_pkg::PTR_PAGE_LSB_8K];
            map.word_in_page_index = ptr[bfp_pkg::PTR_WORD_TOP_8K:bfp_pkg::PTR_WORD_LSB];
            map.stall_read_section = (pc >= bfp_pkg::STALL_BASE_8K);
            map.in_boot = (pc >= vec) && (pc <= bfp_pkg::FLASH_END_8K);
        end else begin
            pc = {1'b0, ptr[bfp_pkg::PTR_PC_TOP_4K:bfp_pkg::PTR_WORD_LSB]};
            map.page_index = ptr[bfp_pkg::PTR_PC_TOP_4K:bfp_pkg::PTR_PAGE_LSB_4K];
            map.word_in_page_index = {1'b0, ptr[bfp_pkg::PTR_WORD_TOP_4K:bfp_pkg::PTR_WORD_LSB]};
            map.stall_read_section = (pc >= bfp_pkg::STALL_BASE_4K);
            map.in_boot = (pc >= vec) && (pc <= bfp_pkg::FLASH_END_4K);
        end
        map.pc = pc;
        map.concurrent_read_section = !map.stall_read_section;
        map.byte_high = ptr[bfp_pkg::PTR_BYTE_BIT];
    end
endmodule // bfp_addr_decode
`default_nettype wire

//--- bfp_flash_timer_model.sv
// flash timing partner: answers each started erase or write after a set delay
`timescale 1ns/1ns
`default_nettype none
module bfp_flash_timer_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic op_start,
    input wire logic [7:0] delay,
    output logic op_done
);
    logic [7:0] cnt_r;
    logic run_r;
    // the delay sets a prompt or a slow answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
            cnt_r <= 8'h00;
            op_done <= 1'b0;
        end else begin
            op_done <= 1'b0;
            if (op_start) begin
                run_r <= 1'b1;
                cnt_r <= delay;
            end else if (run_r) begin
                if (cnt_r == 8'h00) begin
                    run_r <= 1'b0;
                    op_done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule // bfp_flash_timer_model
`default_nettype wire

//--- bfp_partition.sv
// partition decode, busy tracking and core halt for flash self-programming
`timescale 1ns/1ns
`default_nettype none
module bfp_partition (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic part_8k,
    input wire logic boot_size_sel_hi,
    input wire logic boot_size_sel_lo,
    input wire bfp_pkg::bfp_req_s req,
    output logic req_ready,
    input wire bfp_pkg::bfp_rd_s rd,
    output logic rd_blocked,
    input wire logic op_done,
    output logic [bfp_pkg::PC_W-1:0] boot_reset_vector,
    output logic op_start,
    output logic op_erase,
    output logic [bfp_pkg::PAGE_W-1:0] op_page,
    output logic fill_strobe,
    output logic [bfp_pkg::WORD_W-1:0] fill_word,
    output logic rd_strobe,
    output logic [bfp_pkg::PC_W-1:0] rd_addr,
    output logic rd_byte_high,
    output logic section_busy_flag,
    output logic core_halt,
    output bfp_pkg::bfp_map_s req_map
);
    logic [1:0] boot_size;
    bfp_pkg::bfp_map_s rd_map;
    bfp_pkg::bfp_core_s cur_r;
    bfp_pkg::bfp_core_s cur_nxt;
    logic take;
    logic is_prog;

    assign boot_size = {boot_size_sel_hi, boot_size_sel_lo};

    bfp_addr_decode u_req_dec (
        .part_8k(part_8k),
        .boot_size(boot_size),
        .ptr(req.ptr),
        .map(req_map)
    );

    bfp_addr_decode u_rd_dec (
        .part_8k(part_8k),
        .boot_size(boot_size),
        .ptr(rd.ptr),
        .map(rd_map)
    );

    // static fuses, so no register between them and the vector
    assign boot_reset_vector = bfp_pkg::boot_start(part_8k, boot_size);

    // new commands wait while an erase or write runs
    assign req_ready = (cur_r.st == bfp_pkg::BFP_ST_IDLE);
    assign take = req.valid && req_ready;
    assign is_prog = (req.cmd == bfp_pkg::BFP_CMD_ERASE) || (req.cmd == bfp_pkg::BFP_CMD_WRITE);

    assign rd_blocked = rd.valid && cur_r.busy && rd_map.concurrent_read_section;
    assign core_halt = (cur_r.st == bfp_pkg::BFP_ST_STALL_OP);
    assign section_busy_flag = cur_r.busy;
    assign op_start = cur_r.op_go;
    assign op_erase = cur_r.op_erase;
    assign op_page = cur_r.op_page;
    assign fill_strobe = cur_r.fill_go;
    assign fill_word = cur_r.fill_word;
    assign rd_strobe = cur_r.rd_go;
    assign rd_addr = cur_r.rd_addr;
    assign rd_byte_high = cur_r.rd_hi;

    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.op_go = 1'b0;
        cur_nxt.fill_go = 1'b0;
        cur_nxt.rd_go = 1'b0;
        case (cur_r.st)
            bfp_pkg::BFP_ST_IDLE: begin
                if (take && is_prog) begin
                    // word index bits are not used for a page operation
                    cur_nxt.op_go = 1'b1;
                    cur_nxt.op_erase = (req.cmd == bfp_pkg::BFP_CMD_ERASE);
                    cur_nxt.op_page = req_map.page_index;
                    if (req_map.stall_read_section) begin
                        cur_nxt.st = bfp_pkg::BFP_ST_STALL_OP;
                    end else begin
                        cur_nxt.st = bfp_pkg::BFP_ST_CONC_OP;
                        cur_nxt.busy = 1'b1;
                    end
                end else if (take && req.cmd == bfp_pkg::BFP_CMD_FILL) begin
                    // pointer bit 0 ignored for a buffer fill
                    cur_nxt.fill_go = 1'b1;
                    cur_nxt.fill_word = req_map.word_in_page_index;
                    cur_nxt.busy = 1'b0;
                end else if (take && req.cmd == bfp_pkg::BFP_CMD_READ_EN) begin
                    cur_nxt.busy = 1'b0;
                end
            end
            bfp_pkg::BFP_ST_CONC_OP: begin
                // busy stays up after completion until a read re-enable or a buffer fill
                if (op_done) begin
                    cur_nxt.st = bfp_pkg::BFP_ST_IDLE;
                end
            end
            bfp_pkg::BFP_ST_STALL_OP: begin
                if (op_done) begin
                    cur_nxt.st = bfp_pkg::BFP_ST_IDLE;
                end
            end
            default: begin
                cur_nxt.st = bfp_pkg::BFP_ST_IDLE;
            end
        endcase
        // a blocked read returns nothing
        if (rd.valid && !rd_blocked) begin
            cur_nxt.rd_go = 1'b1;
            cur_nxt.rd_addr = rd_map.pc;
            cur_nxt.rd_hi = rd_map.byte_high;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_boot_vec_4k: assert property (!part_8k && boot_size == bfp_pkg::BSZ_128 |-> boot_reset_vector == 13'h0F80)
        else $error("4k boot vector wrong");
    a_boot_vec_8k: assert property (part_8k && boot_size == 2'h0 |-> boot_reset_vector == 13'h1C00
        && (req_map.in_boot == (req_map.pc >= 13'h1C00)))
        else $error("8k boot vector or region wrong");
    a_conc_sect_4k: assert property (!part_8k |-> req_map.concurrent_read_section == (req.ptr[12:1] < 12'hC00))
        else $error("4k section split wrong");
    a_conc_sect_8k: assert property (part_8k |-> req_map.stall_read_section == (req.ptr[13:1] >= 13'h1C00))
        else $error("8k section split wrong");
    a_page_split_4k: assert property (!part_8k |-> req_map.page_index == req.ptr[12:6]
        && req_map.word_in_page_index == {1'b0, req.ptr[5:1]})
        else $error("4k pointer split wrong");
    a_page_split_8k: assert property (part_8k |-> req_map.page_index == req.ptr[13:7]
        && req_map.word_in_page_index == req.ptr[6:1])
        else $error("8k pointer split wrong");
    a_pc_shift: assert property (req_map.pc[11:0] == req.ptr[12:1])
        else $error("word address not shifted");
    a_top_ignored: assert property (!part_8k |-> req_map.pc[12] == 1'b0)
        else $error("ignored pointer bits used");
    a_op_page: assert property (take && is_prog |=> op_start && op_page == $past(req_map.page_index))
        else $error("page operation page wrong");
    a_byte_sel: assert property (rd.valid && !rd_blocked |=> rd_strobe && rd_byte_high == $past(rd.ptr[0]))
        else $error("byte select wrong");
    a_busy_blocks: assert property (take && is_prog && req_map.concurrent_read_section
        |=> section_busy_flag throughout (!req_ready)[*1])
        else $error("busy not set");
    a_read_blocked: assert property (section_busy_flag && rd.valid && rd_map.concurrent_read_section |=> !rd_strobe)
        else $error("read passed while busy");
    a_halt_stall: assert property (take && is_prog && req_map.stall_read_section
        |=> core_halt && section_busy_flag == $past(section_busy_flag))
        else $error("core not halted");
    // halt spans the whole operation and ends with it
    a_halt_hold: assert property (core_halt && !op_done |=> core_halt)
        else $error("halt dropped before completion");
    a_halt_release: assert property (core_halt && op_done |=> !core_halt && req_ready)
        else $error("halt not released");

    // fuse decode corners not covered above
    a_boot_vec_mid: assert property (part_8k && boot_size == 2'h1 |-> boot_reset_vector == 13'h1E00)
        else $error("8k boot vector wrong");
    a_in_boot_4k: assert property (!part_8k && boot_size == 2'h2
        |-> req_map.in_boot == (req.ptr[12:1] >= 12'hF00))
        else $error("4k boot region wrong");
    a_top_8k: assert property (part_8k |-> req_map.pc == req.ptr[13:1])
        else $error("8k ignored pointer bits used");

    // page operations, buffer fill and read address
    a_op_kind: assert property (take && is_prog
        |=> op_erase == ($past(req.cmd) == bfp_pkg::BFP_CMD_ERASE))
        else $error("erase or write kind wrong");
    a_one_start: assert property (op_start |=> !op_start)
        else $error("operation started twice");
    a_fill_word: assert property (take && req.cmd == bfp_pkg::BFP_CMD_FILL
        |=> fill_strobe && fill_word == $past(req_map.word_in_page_index))
        else $error("fill word wrong");
    a_rd_addr: assert property (rd.valid && !rd_blocked |=> rd_addr == $past(rd_map.pc))
        else $error("read address wrong");

    // section busy flag life cycle
    a_fill_clears: assert property (take && req.cmd == bfp_pkg::BFP_CMD_FILL |=> !section_busy_flag)
        else $error("fill left busy set");
    a_reenable_clr: assert property (take && req.cmd == bfp_pkg::BFP_CMD_READ_EN |=> !section_busy_flag)
        else $error("re-enable left busy set");
    a_busy_hold: assert property (section_busy_flag && !(take && (req.cmd == bfp_pkg::BFP_CMD_FILL
        || req.cmd == bfp_pkg::BFP_CMD_READ_EN)) |=> section_busy_flag)
        else $error("busy dropped early");
    a_busy_source: assert property (!section_busy_flag
        && !(take && is_prog && req_map.concurrent_read_section) |=> !section_busy_flag)
        else $error("busy set without concurrent operation");
    a_stall_reads: assert property (rd.valid && rd_map.stall_read_section |-> !rd_blocked)
        else $error("stall section read blocked");

    c_conc_write: cover property (take && req.cmd == bfp_pkg::BFP_CMD_WRITE && req_map.concurrent_read_section);
    c_stall_erase: cover property (take && req.cmd == bfp_pkg::BFP_CMD_ERASE && req_map.stall_read_section);
    c_blocked_read: cover property (rd_blocked);
    c_reenable: cover property (section_busy_flag && take && req.cmd == bfp_pkg::BFP_CMD_READ_EN);
    c_fill_clears: cover property (section_busy_flag && take && req.cmd == bfp_pkg::BFP_CMD_FILL);
endmodule // bfp_partition
`default_nettype wire

//--- bfp_pkg.sv
// package: constants, types and decode helpers for boot flash partition decode
package bfp_pkg;
    localparam int PTR_W = 16;
    localparam int PC_W = 13;
    localparam int PAGE_W = 7;
    localparam int WORD_W = 6;

    // pointer field positions per part
    localparam int PTR_BYTE_BIT = 0;
    localparam int PTR_WORD_LSB = 1;
    localparam int PTR_PC_TOP_4K = 12;
    localparam int PTR_PC_TOP_8K = 13;
    localparam int PTR_WORD_TOP_4K = 5;
    localparam int PTR_WORD_TOP_8K = 6;
    localparam int PTR_PAGE_LSB_4K = 6;
    localparam int PTR_PAGE_LSB_8K = 7;

    localparam logic [PC_W-1:0] BOOT_4K_128 = 13'h0F80;
    localparam logic [PC_W-1:0] BOOT_4K_256 = 13'h0F00;
    localparam logic [PC_W-1:0] BOOT_4K_512 = 13'h0E00;
    localparam logic [PC_W-1:0] BOOT_4K_1024 = 13'h0C00;
    localparam logic [PC_W-1:0] BOOT_8K_128 = 13'h1F80;
    localparam logic [PC_W-1:0] BOOT_8K_256 = 13'h1F00;
    localparam logic [PC_W-1:0] BOOT_8K_512 = 13'h1E00;
    localparam logic [PC_W-1:0] BOOT_8K_1024 = 13'h1C00;
    localparam logic [PC_W-1:0] FLASH_END_4K = 13'h0FFF;
    localparam logic [PC_W-1:0] FLASH_END_8K = 13'h1FFF;
    localparam logic [PC_W-1:0] STALL_BASE_4K = 13'h0C00;
    localparam logic [PC_W-1:0] STALL_BASE_8K = 13'h1C00;
    localparam int CONC_PAGES_4K = 96;
    localparam int CONC_PAGES_8K = 112;

    localparam logic [1:0] BSZ_128 = 2'h3;
    localparam logic [1:0] BSZ_256 = 2'h2;
    localparam logic [1:0] BSZ_512 = 2'h1;

    typedef enum logic [2:0] {
        BFP_CMD_NONE,
        BFP_CMD_FILL,
        BFP_CMD_ERASE,
        BFP_CMD_WRITE,
        BFP_CMD_READ_EN
    } bfp_cmd_e;

    typedef enum logic [1:0] {
        BFP_ST_IDLE,
        BFP_ST_CONC_OP,
        BFP_ST_STALL_OP
    } bfp_state_e;

    typedef struct packed {
        logic valid;
        bfp_cmd_e cmd;
        logic [PTR_W-1:0] ptr;
    } bfp_req_s;

    typedef struct packed {
        logic valid;
        logic [PTR_W-1:0] ptr;
    } bfp_rd_s;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [PAGE_W-1:0] page_index;
        logic [WORD_W-1:0] word_in_page_index;
        logic byte_high;
        logic in_boot;
        logic concurrent_read_section;
        logic stall_read_section;
    } bfp_map_s;

    typedef struct packed {
        bfp_state_e st;
        logic busy;
        logic op_go;
        logic op_erase;
        logic [PAGE_W-1:0] op_page;
        logic fill_go;
        logic [WORD_W-1:0] fill_word;
        logic rd_go;
        logic [PC_W-1:0] rd_addr;
        logic rd_hi;
    } bfp_core_s;

    function automatic logic [PC_W-1:0] boot_start(input logic part_8k, input logic [1:0] sz);
        logic [PC_W-1:0] s;
        case (sz)
            BSZ_128: s = part_8k ? BOOT_8K_128 : BOOT_4K_128;
            BSZ_256: s = part_8k ? BOOT_8K_256 : BOOT_4K_256;
            BSZ_512: s = part_8k ? BOOT_8K_512 : BOOT_4K_512;
            default: s = part_8k ? BOOT_8K_1024 : BOOT_4K_1024;
        endcase
        return s;
    endfunction
endpackage

//--- tb_boot_flash_partition_decode.sv
// testbench: boot vectors, pointer decode, section busy and core halt
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_boot_flash_partition_decode;
    logic ref_clk = 1'b0, rst = 1'b1, part_8k = 1'b0, sz_hi = 1'b0, sz_lo = 1'b0, op_done;
    bfp_pkg::bfp_req_s req = '0;
    bfp_pkg::bfp_rd_s rd = '0;
    bfp_pkg::bfp_map_s map;
    logic req_ready, rd_blocked, op_start, op_erase, fill_strobe, rd_strobe, rd_byte_high, busy, halt;
    logic [bfp_pkg::PC_W-1:0] boot_vec, rd_addr;
    logic [bfp_pkg::PAGE_W-1:0] op_page;
    logic [bfp_pkg::WORD_W-1:0] fill_word;
    logic [7:0] dly = 8'h14;
    logic [31:0] seed = 32'h4;
    logic [15:0] p;
    logic [12:0] pc;
    logic [15:0] corner [4] = '{16'hF7FE, 16'hB7FE, 16'h1800, 16'h3801};
    int fail_count = 0, checks_done = 0, cycles = 0;
    always #4 ref_clk = ~ref_clk;
    bfp_partition DUT (.ref_clk(ref_clk), .rst(rst), .part_8k(part_8k), .boot_size_sel_hi(sz_hi),
        .boot_size_sel_lo(sz_lo), .req(req), .req_ready(req_ready), .rd(rd), .rd_blocked(rd_blocked),
        .op_done(op_done), .boot_reset_vector(boot_vec), .op_start(op_start), .op_erase(op_erase),
        .op_page(op_page), .fill_strobe(fill_strobe), .fill_word(fill_word), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .rd_byte_high(rd_byte_high), .section_busy_flag(busy), .core_halt(halt),
        .req_map(map));
    bfp_flash_timer_model flash (.ref_clk(ref_clk), .rst(rst), .op_start(op_start), .delay(dly),
        .op_done(op_done));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [12:0] exp_boot(logic k, logic [1:0] s);
        logic [12:0] b [4] = '{13'h0C00, 13'h0E00, 13'h0F00, 13'h0F80};
        return b[s] | {k, 12'h000};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // store pointers keep bit 0 at zero and page writes keep word bits at zero
    task automatic issue(bfp_pkg::bfp_cmd_e c, logic [15:0] ptr);
        @(negedge ref_clk);
        req.valid = 1'b1;
        req.cmd = c;
        req.ptr = ptr;
        #1 `CHK("req_ready", 1'b1, req_ready)
        @(negedge ref_clk);
        req.valid = 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("idle_wait", 1'b1, req_ready)
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            part_8k = i[2];
            {sz_hi, sz_lo} = i[1:0];
            #1 `CHK("boot_vec", exp_boot(i[2], i[1:0]), boot_vec)
        end
        $display("test boot vectors done");
        for (int i = 0; i < 64; i++) begin
            @(negedge ref_clk);
            part_8k = i[0];
            p = (i < 4) ? corner[i] : 16'(xs());
            req.ptr = p;
            pc = part_8k ? p[13:1] : {1'b0, p[12:1]};
            #1 `CHK("pc", pc, map.pc)
            `CHK("page", part_8k ? p[13:7] : p[12:6], map.page_index)
            `CHK("word", part_8k ? p[6:1] : {1'b0, p[5:1]}, map.word_in_page_index)
            `CHK("byte_hi", p[0], map.byte_high)
            `CHK("conc", pc < (part_8k ? 13'h1C00 : 13'h0C00), map.concurrent_read_section)
            `CHK("stall", pc >= (part_8k ? 13'h1C00 : 13'h0C00), map.stall_read_section)
            `CHK("in_boot", pc >= exp_boot(part_8k, {sz_hi, sz_lo}), map.in_boot)
        end
        $display("test pointer decode done");
        @(negedge ref_clk);
        part_8k = 1'b0;
        {sz_hi, sz_lo} = 2'h0;
        p = 16'(xs()) & 16'hFFFE;
        issue(bfp_pkg::BFP_CMD_FILL, p);
        `CHK("fill_strobe", 1'b1, fill_strobe)
        `CHK("fill_word", {1'b0, p[5:1]}, fill_word)
        issue(bfp_pkg::BFP_CMD_WRITE, 16'h0A40);
        `CHK("op_start", 1'b1, op_start)
        `CHK("op_erase", 1'b0, op_erase)
        `CHK("op_page", 7'h29, op_page)
        `CHK("busy_set", 1'b1, busy)
        `CHK("no_halt", 1'b0, halt)
        rd.valid = 1'b1;
        rd.ptr = 16'h0101;
        #1 `CHK("rd_blocked", 1'b1, rd_blocked)
        @(negedge ref_clk);
        `CHK("rd_strobe_off", 1'b0, rd_strobe)
        rd.ptr = 16'h1803;
        #1 `CHK("rd_open", 1'b0, rd_blocked)
        @(negedge ref_clk);
        rd.valid = 1'b0;
        `CHK("rd_strobe", 1'b1, rd_strobe)
        `CHK("rd_addr", 13'h0C01, rd_addr)
        `CHK("rd_byte", 1'b1, rd_byte_high)
        wait_idle();
        `CHK("busy_hold", 1'b1, busy)
        issue(bfp_pkg::BFP_CMD_READ_EN, 16'h0000);
        `CHK("busy_clr", 1'b0, busy)
        $display("test concurrent write done");
        part_8k = 1'b1;
        dly = 8'(xs()) & 8'h3F;
        issue(bfp_pkg::BFP_CMD_ERASE, 16'h3880);
        `CHK("op_erase", 1'b1, op_erase)
        `CHK("op_page8", 7'h71, op_page)
        `CHK("halt_on", 1'b1, halt)
        `CHK("busy_off", 1'b0, busy)
        wait_idle();
        `CHK("halt_off", 1'b0, halt)
        $display("test stall erase done");
        issue(bfp_pkg::BFP_CMD_ERASE, 16'h0100);
        `CHK("op_page8c", 7'h02, op_page)
        `CHK("busy8", 1'b1, busy)
        `CHK("refused", 1'b0, req_ready)
        wait_idle();
        issue(bfp_pkg::BFP_CMD_FILL, 16'h0046);
        `CHK("fill_word8", 6'h23, fill_word)
        `CHK("fill_clr", 1'b0, busy)
        $display("test fill re-enable done");
        complete_run();
    end
endmodule // tb_boot_flash_partition_decode
`default_nettype wire
